// [pkg/ifd_defines.svh]
// Field positions, widths and fixed values of the instruction decoder.
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH

// ----------------------------------------------------------------------
// Halfword field positions
// ----------------------------------------------------------------------
`define IFD_DBANK_BIT    9
`define IFD_SBANK_BIT    8
`define IFD_IMM_HI_BIT   8
`define IFD_DCODE_HI     7
`define IFD_DCODE_LO     4
`define IFD_SCODE_HI     3
`define IFD_SCODE_LO     0
`define IFD_REL_FMT_BIT  7
`define IFD_REL_SIGN_BIT 0

// ----------------------------------------------------------------------
// Bank codes, lengths and fixed values
// ----------------------------------------------------------------------
`define IFD_BANK_GLOBAL  1'h0
`define IFD_BANK_LOCAL   1'h1
`define IFD_LEN_ONE      2'h1
`define IFD_LEN_TWO      2'h2
`define IFD_FRM_ZERO_LEN 5'h10
`define IFD_PAGE_ONES    24'hFFFFFF
`define IFD_SHIFT_BITS   5

`endif

// [pkg/ifd_pkg.sv]
// Types shared by the instruction decoder and its bench.
package ifd_pkg;

  // ----------------------------------------------------------------------
  // Instruction formats
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_LOCAL_PAIR      = 3'h0,
    FMT_EXT_LOCAL_PAIR  = 3'h1,
    FMT_LOCAL_ANY       = 3'h2,
    FMT_ANY_ANY         = 3'h3,
    FMT_LOCAL_SHORT_IMM = 3'h4,
    FMT_REG_SHORT_IMM   = 3'h5,
    FMT_ABS_PAGE        = 3'h6,
    FMT_PC_OFFSET       = 3'h7
  } ifd_fmt_t;

  // Instruction class bits from the opcode lookup.
  typedef struct packed {
    logic is_load;
    logic is_shift;
    logic is_double;
  } ifd_cls_t;

  // Decoded operands; registers are {bank, code}, bank 1 = local.
  typedef struct packed {
    ifd_fmt_t    fmt;
    ifd_cls_t    cls;
    logic [1:0]  len;
    logic [4:0]  src_reg;
    logic [4:0]  dst_reg;
    logic [4:0]  src_lo;
    logic [4:0]  dst_lo;
    logic [4:0]  imm5;
    logic [15:0] ext_op;
    logic [31:0] target;
  } ifd_ops_t;

  // Build-up states for multi-halfword instructions.
  typedef enum logic {
    ST_FIRST = 1'b0,
    ST_EXT   = 1'b1
  } ifd_st_t;

endpackage

// [logic/ifd_decode.sv]
// Two-stage instruction decode and execute control with load interlock.
//
// Behaviour
// - Shifts and rotates use only the low five source bits as count.
// - Stage one fetches and decodes; stage two executes the previous one.
// - Operands read and result written in the same execute cycle.
// - Sources stay unchanged unless also destination; loads use source field.
// - Updated flags become one on true condition, zero on false.
// - Range-error trap follows the flag and destination update.
// - Next instruction uses prior result and flags without delay.
// - Stall while a pending load register is needed as source or destination.
// - Frame length zero counts as sixteen usable local registers.
// - Double words: named register high, register one higher low.
// - Instructions are one or two halfwords, starting at any halfword.
// - Source bank bit selects globals at zero, locals at one.
// - Destination bank bit selects globals at zero, locals at one.
// - Short immediate is bit 8 then bits 3 to 0.
// - Local pair formats always name local registers.
// - Extended local pair decodes a second opcode-extension halfword.
// - Page address is 24 ones, byte bits 7 to 2, two zeros.
// - Short PC offset is sign times 25, low field, zero.
// - Long PC offset is sign times 9, high, low fields, zero.
// - Loads use the source-position field as the load destination.
`timescale 1ns/1ns
`include "ifd_defines.svh"

module ifd_decode #(
  parameter int FRM_W = 4
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              hw_valid,
  input  wire logic [15:0]       hw_data,
  input  ifd_pkg::ifd_fmt_t      fmt_in,
  input  ifd_pkg::ifd_cls_t      cls_in,
  input  wire logic              ld_done,
  input  wire logic              range_err,
  input  wire logic [3:0]        flag_upd,
  input  wire logic [3:0]        flag_cond,
  input  wire logic [FRM_W-1:0]  frame_length_field,
  input  wire logic [31:0]       src_word,
  output logic                   hw_ready_q,
  output logic                   ex_valid_q,
  output ifd_pkg::ifd_ops_t      ex_ops_q,
  output logic                   wb_en_q,
  output logic [31:0]            opnd_q,
  output logic [3:0]             flags_q,
  output logic                   trap_q,
  output logic                   stall_q,
  output logic [4:0]             frame_len_q,
  output logic                   local_oob_q
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (FRM_W != 4) begin : g_bad_frame_w
    $error("ifd_decode: frame length field must be four bits wide");
  end

  // ----------------------------------------------------------------------
  // Length and field decode
  // ----------------------------------------------------------------------

  // Halfword count of an instruction from its first halfword.
  function automatic logic [1:0] ifd_len(input ifd_pkg::ifd_fmt_t f,
                                         input logic [15:0] h);
    logic [1:0] n;
    n = `IFD_LEN_ONE;
    if (f == ifd_pkg::FMT_EXT_LOCAL_PAIR) begin
      n = `IFD_LEN_TWO;
    end
    if (f == ifd_pkg::FMT_PC_OFFSET && h[`IFD_REL_FMT_BIT]) begin
      n = `IFD_LEN_TWO;
    end
    return n;
  endfunction

  // Full operand decode of one instruction.
  function automatic ifd_pkg::ifd_ops_t ifd_dec(input ifd_pkg::ifd_fmt_t f,
                                                input ifd_pkg::ifd_cls_t c,
                                                input logic [15:0] h0,
                                                input logic [15:0] h1);
    ifd_pkg::ifd_ops_t o;
    logic [3:0]        dc;
    logic [3:0]        sc;
    logic              db;
    logic              sb;
    o      = '0;
    dc     = h0[`IFD_DCODE_HI:`IFD_DCODE_LO];
    sc     = h0[`IFD_SCODE_HI:`IFD_SCODE_LO];
    db     = `IFD_BANK_LOCAL;
    sb     = `IFD_BANK_LOCAL;
    o.fmt  = f;
    o.cls  = c;
    o.len  = ifd_len(f, h0);
    o.imm5 = {h0[`IFD_IMM_HI_BIT], sc};
    case (f)
      ifd_pkg::FMT_EXT_LOCAL_PAIR: begin
        o.ext_op = h1;
      end
      ifd_pkg::FMT_LOCAL_ANY: begin
        sb = h0[`IFD_SBANK_BIT];
      end
      ifd_pkg::FMT_ANY_ANY: begin
        sb = h0[`IFD_SBANK_BIT];
        db = h0[`IFD_DBANK_BIT];
      end
      ifd_pkg::FMT_REG_SHORT_IMM: begin
        db = h0[`IFD_DBANK_BIT];
      end
      ifd_pkg::FMT_ABS_PAGE: begin
        o.target = {`IFD_PAGE_ONES, h0[7:2], 2'h0};
      end
      ifd_pkg::FMT_PC_OFFSET: begin
        if (!h0[`IFD_REL_FMT_BIT]) begin
          o.target = {{25{h0[`IFD_REL_SIGN_BIT]}}, h0[6:1], 1'h0};
        end else begin
          o.target = {{9{h1[`IFD_REL_SIGN_BIT]}}, h0[6:0], h1[15:1], 1'h0};
        end
      end
      default: begin
        o.ext_op = 16'h0000;
      end
    endcase
    if (c.is_load) begin
      o.dst_reg = {sb, sc};
      o.src_reg = {db, dc};
    end else begin
      o.dst_reg = {db, dc};
      o.src_reg = {sb, sc};
    end
    o.src_lo = {o.src_reg[4], o.src_reg[3:0] + 4'h1};
    o.dst_lo = {o.dst_reg[4], o.dst_reg[3:0] + 4'h1};
    return o;
  endfunction

  // ----------------------------------------------------------------------
  // Stage one: halfword collection
  // ----------------------------------------------------------------------
  ifd_pkg::ifd_st_t  st_q;
  ifd_pkg::ifd_st_t  st_d;
  ifd_pkg::ifd_fmt_t b_fmt_q;
  ifd_pkg::ifd_cls_t b_cls_q;
  logic [15:0]       b_h0_q;
  logic              dec_full_q;
  logic              dec_full_d;
  ifd_pkg::ifd_ops_t dec_ops_q;
  logic              pend_v_q;
  logic              pend_v_d;
  logic [4:0]        pend_reg_q;
  logic [4:0]        pend_reg_d;

  // Halfwords may start anywhere; no alignment is assumed.
  wire logic              take     = hw_valid & hw_ready_q;
  wire logic [1:0]        first_n  = ifd_len(fmt_in, hw_data);
  wire logic              done_one = take & (st_q == ifd_pkg::ST_FIRST)
                                     & (first_n == `IFD_LEN_ONE);
  wire logic              done_ext = take & (st_q == ifd_pkg::ST_EXT);
  wire logic              complete = done_one | done_ext;
  wire ifd_pkg::ifd_ops_t new_ops  = done_ext
                                     ? ifd_dec(b_fmt_q, b_cls_q, b_h0_q, hw_data)
                                     : ifd_dec(fmt_in, cls_in, hw_data, 16'h0000);

  // Collection state steps to the extension halfword when needed.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ifd_pkg::ST_FIRST: begin
        if (take && first_n == `IFD_LEN_TWO) begin
          st_d = ifd_pkg::ST_EXT;
        end
      end
      ifd_pkg::ST_EXT: begin
        if (take) begin
          st_d = ifd_pkg::ST_FIRST;
        end
      end
      default: begin
        st_d = ifd_pkg::ST_FIRST;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Load interlock
  // ----------------------------------------------------------------------

  // Fields a format names as registers: bit 1 destination, bit 0 source.
  function automatic logic [1:0] ifd_uses(input ifd_pkg::ifd_fmt_t f);
    logic [1:0] u;
    u = 2'h3;
    case (f)
      ifd_pkg::FMT_LOCAL_SHORT_IMM,
      ifd_pkg::FMT_REG_SHORT_IMM: begin
        u = 2'h2;
      end
      ifd_pkg::FMT_ABS_PAGE,
      ifd_pkg::FMT_PC_OFFSET: begin
        u = 2'h0;
      end
      default: begin
        u = 2'h3;
      end
    endcase
    return u;
  endfunction

  // A pending load target, or any load while a load is pending, holds back the instruction in decode.
  function automatic logic ifd_haz(input logic v, input logic [4:0] r,
                                   input ifd_pkg::ifd_ops_t o);
    logic       hit;
    logic [1:0] u;
    u   = ifd_uses(o.fmt);
    hit = (u[0] & (o.src_reg == r)) | (u[1] & (o.dst_reg == r)) | o.cls.is_load;
    if (o.cls.is_double) begin
      hit = hit | (u[0] & (o.src_lo == r)) | (u[1] & (o.dst_lo == r));
    end
    return v & hit;
  endfunction

  wire logic hazard = ifd_haz(pend_v_q & ~ld_done, pend_reg_q, dec_ops_q);
  wire logic issue  = dec_full_q & ~hazard;
  wire logic ld_iss = issue & dec_ops_q.cls.is_load;

  // Pending load record; a new load issue wins over a same-cycle arrival.
  always_comb begin
    pend_v_d   = pend_v_q & ~ld_done;
    pend_reg_d = pend_reg_q;
    if (ld_iss) begin
      pend_v_d   = 1'b1;
      pend_reg_d = dec_ops_q.dst_reg;
    end
  end

  // Decode slot occupancy and the ready offered for the next cycle.
  wire ifd_pkg::ifd_ops_t slot_d = complete ? new_ops : dec_ops_q;
  assign dec_full_d = complete | (dec_full_q & ~issue);
  wire logic ready_d = ~dec_full_d | ~ifd_haz(pend_v_d, pend_reg_d, slot_d);

  // ----------------------------------------------------------------------
  // Frame length and flag handling
  // ----------------------------------------------------------------------
  wire logic [4:0] frame_len_d = (frame_length_field == 4'h0)
                                 ? `IFD_FRM_ZERO_LEN
                                 : {1'b0, frame_length_field};

  // Only fields that the format really names as registers count against the frame.
  wire logic [1:0] ex_uses = ifd_uses(ex_ops_q.fmt);
  wire logic       oob_src = ex_uses[0] & ex_ops_q.src_reg[4]
                             & ({1'b0, ex_ops_q.src_reg[3:0]} >= frame_len_d);
  wire logic       oob_dst = ex_uses[1] & ex_ops_q.dst_reg[4]
                             & ({1'b0, ex_ops_q.dst_reg[3:0]} >= frame_len_d);

  // Each updated flag follows its condition; others hold.
  wire logic [3:0] flags_d = (flag_upd & flag_cond) | (~flag_upd & flags_q);

  // Shift counts see only the low bits; all else sees the whole word.
  wire logic [31:0] opnd_d = ex_ops_q.cls.is_shift
                             ? {27'h0, src_word[`IFD_SHIFT_BITS-1:0]}
                             : src_word;

  // ----------------------------------------------------------------------
  // Stage one registers
  // ----------------------------------------------------------------------

  // Collection state, build halfword and decode slot.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q       <= ifd_pkg::ST_FIRST;
      b_fmt_q    <= ifd_pkg::FMT_LOCAL_PAIR;
      b_cls_q    <= '0;
      b_h0_q     <= 16'h0000;
      dec_full_q <= 1'b0;
      dec_ops_q  <= '0;
      hw_ready_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      dec_full_q <= dec_full_d;
      dec_ops_q  <= slot_d;
      hw_ready_q <= ready_d;
      if (take && st_q == ifd_pkg::ST_FIRST) begin
        b_fmt_q <= fmt_in;
        b_cls_q <= cls_in;
        b_h0_q  <= hw_data;
      end
    end
  end

  // Interlock record and its visible stall.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_v_q   <= 1'b0;
      pend_reg_q <= 5'h00;
      stall_q    <= 1'b0;
    end else begin
      pend_v_q   <= pend_v_d;
      pend_reg_q <= pend_reg_d;
      stall_q    <= dec_full_q & hazard;
    end
  end

  // ----------------------------------------------------------------------
  // Stage two registers
  // ----------------------------------------------------------------------

  // Execute stage: operands read and result written in the same cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ex_valid_q <= 1'b0;
      ex_ops_q   <= '0;
      wb_en_q    <= 1'b0;
    end else begin
      ex_valid_q <= issue;
      wb_en_q    <= issue & ~dec_ops_q.cls.is_load;
      if (issue) begin
        ex_ops_q <= dec_ops_q;
      end
    end
  end

  // Results of the execute cycle: operand, flags, trap and frame checks.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opnd_q      <= 32'h00000000;
      flags_q     <= 4'h0;
      trap_q      <= 1'b0;
      frame_len_q <= `IFD_FRM_ZERO_LEN;
      local_oob_q <= 1'b0;
    end else begin
      opnd_q      <= opnd_d;
      frame_len_q <= frame_len_d;
      if (ex_valid_q) begin
        flags_q <= flags_d;
      end
      trap_q      <= ex_valid_q & range_err;
      local_oob_q <= ex_valid_q & (oob_src | oob_dst);
    end
  end

endmodule // ifd_decode

// [tb/ifd_decode_chk.sv]
// Port-level assertions for the instruction decoder.
`timescale 1ns/1ns
module ifd_decode_chk #(
  parameter int FRM_W = 4
) (
  input wire logic            mclk,
  input wire logic            sys_rst,
  input wire logic            ld_done,
  input wire logic            range_err,
  input wire logic [3:0]      flag_upd,
  input wire logic [3:0]      flag_cond,
  input wire logic [FRM_W-1:0] frame_length_field,
  input wire logic [31:0]     src_word,
  input wire logic            ex_valid_q,
  input ifd_pkg::ifd_ops_t    ex_ops_q,
  input wire logic            wb_en_q,
  input wire logic [31:0]     opnd_q,
  input wire logic [3:0]      flags_q,
  input wire logic            trap_q,
  input wire logic            stall_q,
  input wire logic [4:0]      frame_len_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Trap and flag updates land on the edge after the executing cycle.
  trap_after_a: assert property (!$past(sys_rst) |-> trap_q == $past(ex_valid_q && range_err))
    else $error("trap does not follow range error");
  flag_update_a: assert property (ex_valid_q |=>
    flags_q == (($past(flags_q) & ~$past(flag_upd)) | ($past(flag_upd) & $past(flag_cond))))
    else $error("flag update wrong");
  flag_hold_a: assert property (!ex_valid_q |=> $stable(flags_q))
    else $error("flags moved without an instruction");
  // Writeback goes with each issue except loads.
  wb_issue_a: assert property (wb_en_q == (ex_valid_q && !ex_ops_q.cls.is_load))
    else $error("writeback enable wrong");
  // Shift counts keep five bits; other operands pass whole.
  shift_mask_a: assert property (ex_ops_q.cls.is_shift && $past(ex_ops_q.cls.is_shift)
    && !$past(sys_rst) |-> opnd_q == {27'h0, $past(src_word[4:0])})
    else $error("shift count not masked");
  opnd_whole_a: assert property (!ex_ops_q.cls.is_shift && !$past(ex_ops_q.cls.is_shift)
    && !$past(sys_rst) |-> opnd_q == $past(src_word))
    else $error("operand not passed whole");
  // The interlock holds issue and releases it right after load data.
  stall_release_a: assert property (stall_q && ld_done |=> ex_valid_q)
    else $error("no issue after load data");
  stall_idle_a: assert property (stall_q |-> !ex_valid_q)
    else $error("issue during stall");
  frame_zero_a: assert property (!$past(sys_rst) |-> frame_len_q ==
    (($past(frame_length_field) == '0) ? 5'h10 : 5'($past(frame_length_field))))
    else $error("frame length wrong");
endmodule // ifd_decode_chk

// [tb/ifd_cache_model.sv]
// Cache and load-return model facing the instruction decoder.
`timescale 1ns/1ns
module ifd_cache_model (
  input  wire logic         mclk,
  input  wire logic         hw_ready_q,
  input  wire logic         ex_valid_q,
  input  ifd_pkg::ifd_ops_t ex_ops_q,
  output logic              hw_valid,
  output logic [15:0]       hw_data,
  output ifd_pkg::ifd_fmt_t fmt_in,
  output ifd_pkg::ifd_cls_t cls_in,
  output logic              ld_done
);
  int ld_lat = 3;

  // Holds a halfword up until the decoder takes it.
  task automatic offer(input logic [15:0] h, input ifd_pkg::ifd_fmt_t f,
                       input ifd_pkg::ifd_cls_t c, output bit ok);
    logic r;
    hw_valid = 1'b1;
    hw_data = h;
    fmt_in = f;
    cls_in = c;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      r = hw_ready_q;
      @(posedge mclk);
      ok = r;
      #1;
    end
  endtask

  // Released data shows the inverse so a stale value cannot pass.
  task automatic idle();
    hw_valid = 1'b0;
    hw_data = ~hw_data;
  endtask

  // Returns load data a fixed number of edges after the load executes.
  initial begin
    hw_valid = 1'b0;
    hw_data = 16'h0000;
    fmt_in = ifd_pkg::FMT_LOCAL_PAIR;
    cls_in = '0;
    ld_done = 1'b0;
    forever begin
      @(posedge mclk);
      #1;
      if (ex_valid_q === 1'b1 && ex_ops_q.cls.is_load === 1'b1) begin
        repeat (ld_lat - 1) @(posedge mclk);
        #1 ld_done = 1'b1;
        @(posedge mclk);
        #1 ld_done = 1'b0;
      end
    end
  end
endmodule // ifd_cache_model

// [tb/instr_format_decode_pipeline_test.sv]
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module instr_format_decode_pipeline_test;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              range_err = 1'b0;
  logic [3:0]        flag_upd = 4'h0;
  logic [3:0]        flag_cond = 4'h0;
  logic [3:0]        frame_length_field = 4'h0;
  logic [31:0]       src_word = 32'h0;
  logic              hw_valid, hw_ready_q, ex_valid_q, wb_en_q, trap_q, stall_q;
  logic              ld_done, local_oob_q;
  logic [15:0]       hw_data;
  logic [31:0]       opnd_q;
  logic [3:0]        flags_q;
  logic [4:0]        frame_len_q;
  ifd_pkg::ifd_fmt_t fmt_in;
  ifd_pkg::ifd_cls_t cls_in;
  ifd_pkg::ifd_ops_t ex_ops_q;
  int                fail_count = 0;
  int                total_checks = 0;
  int                n;
  bit                stl;

  // Clock and the two facing blocks.
  always #5 mclk = ~mclk;
  ifd_decode uut (.mclk, .sys_rst, .hw_valid, .hw_data, .fmt_in, .cls_in, .ld_done, .range_err,
    .flag_upd, .flag_cond, .frame_length_field, .src_word, .hw_ready_q, .ex_valid_q, .ex_ops_q,
    .wb_en_q, .opnd_q, .flags_q, .trap_q, .stall_q, .frame_len_q, .local_oob_q);
  ifd_cache_model cache (.mclk, .hw_ready_q, .ex_valid_q, .ex_ops_q, .hw_valid, .hw_data,
    .fmt_in, .cls_in, .ld_done);

  // ------
  // Shared tasks
  // ------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    end_of_test();
  endtask
  task automatic put(input logic [15:0] h, input ifd_pkg::ifd_fmt_t f, input ifd_pkg::ifd_cls_t c);
    bit ok;
    cache.offer(h, f, c, ok);
    if (!ok) hang();
  endtask
  // Waits for the next issue, counting edges and noting any stall.
  task automatic wait_ex();
    stl = 1'b0;
    for (n = 1; n < 40; n++) begin
      @(posedge mclk);
      #1;
      if (stall_q === 1'b1) stl = 1'b1;
      if (ex_valid_q === 1'b1) return;
    end
    hang();
  endtask
  task automatic run1(input logic [15:0] h, input ifd_pkg::ifd_fmt_t f, input ifd_pkg::ifd_cls_t c);
    put(h, f, c);
    cache.idle();
    wait_ex();
    `CHK(n, 1)
    `CHK(ex_ops_q.len, 2'h1)
  endtask
  task automatic run2(input logic [15:0] h0, input logic [15:0] h1, input ifd_pkg::ifd_fmt_t f);
    put(h0, f, '0);
    put(h1, f, '0);
    cache.idle();
    wait_ex();
    `CHK(n, 1)
    `CHK(ex_ops_q.len, 2'h2)
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_frame();
    `CHK(frame_len_q, 5'h10)
    `CHK(hw_ready_q, 1'b1)
    frame_length_field = 4'h7;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(frame_len_q, 5'h07)
    run1(16'h0081, ifd_pkg::FMT_LOCAL_PAIR, '0);
    @(posedge mclk);
    #1;
    `CHK(local_oob_q, 1'b1)
    frame_length_field = 4'h0;
    $display("t_frame done");
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      run1({6'h00, b[1:0], 8'hA5}, ifd_pkg::FMT_ANY_ANY, '0);
      `CHK(ex_ops_q.dst_reg, {b[1], 4'hA})
      `CHK(ex_ops_q.src_reg, {b[0], 4'h5})
    end
    run1(16'h0037, ifd_pkg::FMT_LOCAL_PAIR, 3'b001);
    `CHK({ex_ops_q.dst_reg, ex_ops_q.src_reg}, {1'b1, 4'h3, 1'b1, 4'h7})
    `CHK({ex_ops_q.dst_lo, ex_ops_q.src_lo}, {5'h14, 5'h18})
    run1(16'h0237, ifd_pkg::FMT_LOCAL_ANY, '0);
    `CHK({ex_ops_q.dst_reg, ex_ops_q.src_reg}, {1'b1, 4'h3, 1'b0, 4'h7})
    $display("t_banks done");
  endtask
  task automatic t_imm();
    run1(16'h0309, ifd_pkg::FMT_LOCAL_SHORT_IMM, '0);
    `CHK(ex_ops_q.imm5, 5'h19)
    run1(16'h02F6, ifd_pkg::FMT_REG_SHORT_IMM, '0);
    `CHK({ex_ops_q.dst_reg, ex_ops_q.imm5}, {1'b1, 4'hF, 5'h06})
    run1(16'h00B7, ifd_pkg::FMT_ABS_PAGE, '0);
    `CHK(ex_ops_q.target, 32'hFFFFFFB4)
    $display("t_imm done");
  endtask
  task automatic t_pc_offset_format();
    run1(16'h0001, ifd_pkg::FMT_PC_OFFSET, '0);
    `CHK(ex_ops_q.target, 32'hFFFFFF80)
    run1(16'h007E, ifd_pkg::FMT_PC_OFFSET, '0);
    `CHK(ex_ops_q.target, 32'h0000007E)
    run2(16'h00D5, 16'hABCD, ifd_pkg::FMT_PC_OFFSET);
    `CHK(ex_ops_q.target, 32'hFFD5ABCC)
    run2(16'h0042, 16'h1234, ifd_pkg::FMT_EXT_LOCAL_PAIR);
    `CHK({ex_ops_q.ext_op, ex_ops_q.dst_reg}, {16'h1234, 5'h14})
    $display("t_pc_offset_format done");
  endtask
  // A load followed at once by a user of its target register.
  task automatic t_load();
    run1(16'h0035, ifd_pkg::FMT_LOCAL_PAIR, 3'b100);
    `CHK({ex_ops_q.dst_reg, ex_ops_q.src_reg}, {5'h15, 5'h13})
    `CHK(wb_en_q, 1'b0)
    put(16'h0051, ifd_pkg::FMT_LOCAL_PAIR, '0);
    `CHK(hw_ready_q, 1'b0)
    cache.idle();
    wait_ex();
    `CHK(n, cache.ld_lat - 1)
    `CHK(stl, 1'b1)
    `CHK(wb_en_q, 1'b1)
    $display("t_load done");
  endtask
  task automatic t_exec();
    flag_upd = 4'hF;
    flag_cond = 4'hA;
    range_err = 1'b1;
    src_word = 32'hFFFFFFF3;
    run1(16'h0012, ifd_pkg::FMT_LOCAL_PAIR, 3'b010);
    @(posedge mclk);
    #1;
    `CHK({flags_q, trap_q, opnd_q, local_oob_q}, {4'hA, 1'b1, 32'h13, 1'b0})
    flag_upd = 4'h3;
    flag_cond = 4'h1;
    range_err = 1'b0;
    run1(16'h0012, ifd_pkg::FMT_LOCAL_PAIR, '0);
    @(posedge mclk);
    #1;
    `CHK({flags_q, trap_q, opnd_q}, {4'h9, 1'b0, 32'hFFFFFFF3})
    $display("t_exec done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    #1;
    t_frame();
    t_banks();
    t_imm();
    t_pc_offset_format();
    t_load();
    t_exec();
    end_of_test();
  end
endmodule // instr_format_decode_pipeline_test

bind ifd_decode ifd_decode_chk #(.FRM_W(FRM_W)) chk (.mclk, .sys_rst, .ld_done, .range_err,
  .flag_upd, .flag_cond, .frame_length_field, .src_word, .ex_valid_q, .ex_ops_q, .wb_en_q,
  .opnd_q, .flags_q, .trap_q, .stall_q, .frame_len_q);
